/* File: verilog/edo_dram_cycle_control.sv */
/*
 Host controller for an EDO page-mode DRAM with two byte column strobes.
 Assumes a requester on core_clk_in and the DRAM pins driven directly;
 each state but ST_WAKE_WAIT and ST_IDLE lasts one 25 ns cycle, which meets the slowest grade.
*/
`timescale 1ns/1ps
module edo_dram_cycle_control #(
    parameter int WAKE_CYCLES = edo_ctrl_pkg::WAKE_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire edo_ctrl_pkg::mem_req_type req_in,
    output logic req_ready_out,
    output logic rdata_valid_out,
    output logic [edo_ctrl_pkg::DATA_W-1:0] rdata_out,
    output logic init_done_out,
    output edo_ctrl_pkg::dram_pins_type pins_out,
    input wire logic [edo_ctrl_pkg::DATA_W-1:0] dq_in,
    output logic [edo_ctrl_pkg::DATA_W-1:0] dq_out,
    output logic [1:0] dq_oe_out
);
    edo_ctrl_pkg::ctrl_state_type state_q, state_d;
    edo_ctrl_pkg::mem_req_type cur_q, cur_d;
    edo_ctrl_pkg::dram_pins_type pins_q, pins_d;
    logic [15:0] wait_q, wait_d;
    logic [3:0] wake_q, wake_d;
    logic [15:0] dq_s1_q, dq_s2_q;
    logic [15:0] rdata_q, rdata_d;
    logic rvalid_q, rvalid_d;
    logic init_q, init_d;
    logic [1:0] oe_q, oe_d;
    logic [15:0] dout_q, dout_d;
    logic refresh_pending, refresh_overrun, served;

    edo_refresh_timer #(
        .INTERVAL(edo_ctrl_pkg::REFRESH_INTERVAL_CYCLES)
    ) u_timer (
        .core_clk_in(core_clk_in),
        .reset_in(reset_in),
        .served_in(served),
        .pending_out(refresh_pending),
        .overrun_out(refresh_overrun)
    );

    always_ff @(posedge core_clk_in)
    begin
        dq_s1_q <= dq_in;
        dq_s2_q <= dq_s1_q;
    end

    always_comb
    begin
        state_d = state_q;
        cur_d = cur_q;
        pins_d = pins_q;
        wait_d = wait_q;
        wake_d = wake_q;
        rdata_d = rdata_q;
        rvalid_d = 1'b0;
        init_d = init_q;
        oe_d = oe_q;
        dout_d = dout_q;
        served = 1'b0;
        case (state_q)
            edo_ctrl_pkg::ST_WAKE_WAIT:
            begin
                wait_d = wait_q + 16'h0001;
                if (wait_q >= 16'(WAKE_CYCLES - 1))
                begin
                    wait_d = 16'h0000;
                    wake_d = 4'h0;
                    state_d = edo_ctrl_pkg::ST_REF_CAS;
                end
            end
            edo_ctrl_pkg::ST_IDLE:
            begin
                if (refresh_overrun)
                begin
                    init_d = 1'b0;
                    wake_d = 4'h0;
                    state_d = edo_ctrl_pkg::ST_REF_CAS;
                end
                else if (refresh_pending)
                begin
                    wake_d = 4'(edo_ctrl_pkg::WAKE_REFRESHES - 1);
                    state_d = edo_ctrl_pkg::ST_REF_CAS;
                end
                else if (req_valid_in)
                begin
                    cur_d = req_in;
                    pins_d.addr = req_in.row;
                    pins_d.write_en_n = 1'b1;
                    state_d = edo_ctrl_pkg::ST_ROW;
                end
            end
            edo_ctrl_pkg::ST_ROW:
            begin
                pins_d.row_strobe_n = 1'b0;
                pins_d.addr = cur_q.col;
                // Early write drops write enable before the column strobe
                pins_d.write_en_n = ~(cur_q.write & ~cur_q.late);
                pins_d.out_en_n = cur_q.write;
                if (cur_q.write & ~cur_q.late)
                begin
                    oe_d = cur_q.byte_en;
                    dout_d = cur_q.wdata;
                end
                state_d = edo_ctrl_pkg::ST_COL;
            end
            edo_ctrl_pkg::ST_COL:
            begin
                pins_d.lower_byte_col_strobe_n = ~cur_q.byte_en[0];
                pins_d.upper_byte_col_strobe_n = ~cur_q.byte_en[1];
                state_d = edo_ctrl_pkg::ST_DATA;
            end
            edo_ctrl_pkg::ST_DATA:
            begin
                if (cur_q.write & cur_q.late)
                begin
                    // Late write: output enable high, write enable falls now
                    pins_d.write_en_n = 1'b0;
                    oe_d = cur_q.byte_en;
                    dout_d = cur_q.wdata;
                end
                // Extra cycle lets read data pass the pin synchroniser
                state_d = edo_ctrl_pkg::ST_RMW_WR;
            end
            edo_ctrl_pkg::ST_RMW_WR:
            begin
                state_d = edo_ctrl_pkg::ST_RELEASE;
            end
            edo_ctrl_pkg::ST_RELEASE:
            begin
                // Write enable stays high on reads until strobes rise
                pins_d.row_strobe_n = 1'b1;
                pins_d.lower_byte_col_strobe_n = 1'b1;
                pins_d.upper_byte_col_strobe_n = 1'b1;
                if (~cur_q.write)
                begin
                    rdata_d = dq_s2_q;
                    rvalid_d = 1'b1;
                end
                state_d = edo_ctrl_pkg::ST_PRECHARGE;
            end
            edo_ctrl_pkg::ST_PRECHARGE:
            begin
                // One cycle with both strobes high clears held data
                pins_d.write_en_n = 1'b1;
                pins_d.out_en_n = 1'b1;
                oe_d = 2'b00;
                if (wake_q < 4'(edo_ctrl_pkg::WAKE_REFRESHES))
                begin
                    state_d = edo_ctrl_pkg::ST_REF_CAS;
                end
                else
                begin
                    state_d = edo_ctrl_pkg::ST_IDLE;
                end
            end
            edo_ctrl_pkg::ST_REF_CAS:
            begin
                // Column strobes before row strobe select internal counter
                pins_d.lower_byte_col_strobe_n = 1'b0;
                pins_d.upper_byte_col_strobe_n = 1'b0;
                pins_d.write_en_n = 1'b1;
                pins_d.out_en_n = 1'b1;
                state_d = edo_ctrl_pkg::ST_REF_RAS;
            end
            edo_ctrl_pkg::ST_REF_RAS:
            begin
                pins_d.row_strobe_n = 1'b0;
                served = 1'b1;
                wake_d = wake_q + 4'h1;
                if (wake_q == 4'(edo_ctrl_pkg::WAKE_REFRESHES - 1))
                begin
                    init_d = 1'b1;
                    wake_d = 4'(edo_ctrl_pkg::WAKE_REFRESHES);
                end
                cur_d.write = 1'b1;
                state_d = edo_ctrl_pkg::ST_RELEASE;
            end
            default:
            begin
                state_d = edo_ctrl_pkg::ST_WAKE_WAIT;
            end
        endcase
    end

    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            state_q <= edo_ctrl_pkg::ST_WAKE_WAIT;
            cur_q <= '0;
            pins_q <= '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 9'h000};
            wait_q <= 16'h0000;
            wake_q <= 4'h0;
            rdata_q <= 16'h0000;
            rvalid_q <= 1'b0;
            init_q <= 1'b0;
            oe_q <= 2'b00;
            dout_q <= 16'h0000;
        end
        else
        begin
            state_q <= state_d;
            cur_q <= cur_d;
            pins_q <= pins_d;
            wait_q <= wait_d;
            wake_q <= wake_d;
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
            init_q <= init_d;
            oe_q <= oe_d;
            dout_q <= dout_d;
        end
    end

    assign req_ready_out = (state_q == edo_ctrl_pkg::ST_IDLE) & ~refresh_pending
        & ~refresh_overrun;
    assign rdata_valid_out = rvalid_q;
    assign rdata_out = rdata_q;
    assign init_done_out = init_q;
    assign pins_out = pins_q;
    assign dq_out = dout_q;
    assign dq_oe_out = oe_q;
endmodule // edo_dram_cycle_control

/* File: verilog/edo_ctrl_pkg.sv */
/*
 Constants, types and state encodings for the EDO DRAM controller.
 Assumes a 40 MHz core clock and a 256K x 16 EDO DRAM on the pins.
*/
// Notes on behaviour
// - Wait 200 us, then eight wake-up refreshes.
// - Repeat wake-up after refresh period overrun; the code repeats the eight refreshes without the 200 us wait.
// - Precharge both strobes high before new cycle.
// - Write enable high through read hold time.
// - Tied-low output enable forbids late writes.
// - Write command is write enable falling.
// - Output enable high during late writes.
// - Hidden refresh may follow a write.
// - Page cycle time between column strobe edges.
// - Refresh all 512 rows every 8 ms.
package edo_ctrl_pkg;
    localparam int CLK_MHZ = 40;
    localparam int WAKE_US = 200;
    localparam int WAKE_CYCLES = WAKE_US * CLK_MHZ;
    localparam int WAKE_REFRESHES = 8;
    localparam int REFRESH_PERIOD_MS = 8;
    localparam int REFRESH_ROWS = 512;
    localparam int REFRESH_INTERVAL_CYCLES =
        (REFRESH_PERIOD_MS * 1000 * CLK_MHZ) / REFRESH_ROWS;
    localparam int PHASE_CYCLES = 1;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 16;
    localparam logic [4:0] TIMER_RESET = 5'h00;
    typedef enum {
        ST_WAKE_WAIT, ST_WAKE_REF, ST_IDLE, ST_ROW, ST_COL, ST_DATA,
        ST_RMW_WR, ST_RELEASE, ST_PRECHARGE, ST_REF_CAS, ST_REF_RAS
    } ctrl_state_type;
    typedef struct packed {
        logic write;
        logic late;
        logic [1:0] byte_en;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [DATA_W-1:0] wdata;
    } mem_req_type;
    typedef struct packed {
        logic row_strobe_n;
        logic lower_byte_col_strobe_n;
        logic upper_byte_col_strobe_n;
        logic write_en_n;
        logic out_en_n;
        logic [ADDR_W-1:0] addr;
    } dram_pins_type;
endpackage

/* File: verilog/edo_refresh_timer.sv */
/*
 Refresh interval timer: raises a refresh request every interval and holds it until served.
 Assumes the main controller clears the pending flag when served.
*/
`timescale 1ns/1ps
module edo_refresh_timer #(
    parameter int INTERVAL = edo_ctrl_pkg::REFRESH_INTERVAL_CYCLES
) (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic served_in,
    output logic pending_out,
    output logic overrun_out
);
    logic [15:0] count_q, count_d;
    logic pend_q, pend_d;
    logic over_q, over_d;
    always_comb
    begin
        count_d = count_q + 16'h0001;
        pend_d = pend_q & ~served_in;
        over_d = over_q;
        if (count_q >= 16'(INTERVAL - 1))
        begin
            count_d = 16'h0000;
            pend_d = 1'b1;
            over_d = pend_q & ~served_in;
        end
        if (served_in)
        begin
            over_d = 1'b0;
        end
    end
    always_ff @(posedge core_clk_in)
    begin
        if (reset_in)
        begin
            count_q <= 16'h0000;
            pend_q <= 1'b0;
            over_q <= 1'b0;
        end
        else
        begin
            count_q <= count_d;
            pend_q <= pend_d;
            over_q <= over_d;
        end
    end
    assign pending_out = pend_q;
    assign overrun_out = over_q;
endmodule // edo_refresh_timer

/* File: tb/edo_ctrl_monitor.sv */
/* Port assertions for the EDO DRAM controller.
 Assumes binding onto edo_dram_cycle_control. */
`timescale 1ns/1ps
module edo_ctrl_monitor (
    input wire logic core_clk_in,
    input wire logic reset_in,
    input wire logic req_valid_in,
    input wire edo_ctrl_pkg::mem_req_type req_in,
    input wire logic req_ready_out,
    input wire logic rdata_valid_out,
    input wire logic init_done_out,
    input wire edo_ctrl_pkg::dram_pins_type pins_out,
    input wire logic [1:0] dq_oe_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (reset_in);
    wire take = req_valid_in && req_ready_out;
    wire lo_n = pins_out.lower_byte_col_strobe_n;
    wire up_n = pins_out.upper_byte_col_strobe_n;
    sequence rd_take;
        take && !req_in.write;
    endsequence
    sequence ew_take;
        take && req_in.write && !req_in.late;
    endsequence
    sequence lw_take;
        take && req_in.write && req_in.late;
    endsequence
    sequence cbr_start;
        $fell(lo_n) && pins_out.row_strobe_n;
    endsequence
    property lane_p;
        take |-> ##3 (lo_n == !$past(req_in.byte_en[0], 3)
            && up_n == !$past(req_in.byte_en[1], 3));
    endproperty
    a_reset_quiet: assert property ($fell(reset_in) |-> pins_out.row_strobe_n && lo_n
        && up_n && dq_oe_out == 2'b00 && !init_done_out) else $error("pins active after reset");
    a_ready_after_init: assert property (req_ready_out |-> init_done_out)
        else $error("ready before wake-up");
    a_read_answer: assert property (rd_take |-> ##[5:6] rdata_valid_out)
        else $error("read answer late");
    a_read_we_high: assert property (rd_take |=> pins_out.write_en_n [*6])
        else $error("write enable low in read");
    a_early_oe_off: assert property (ew_take |-> ##[1:2] (!pins_out.write_en_n
        && pins_out.out_en_n)) else $error("early write order");
    a_late_oe_high: assert property (lw_take |=> pins_out.out_en_n [*6])
        else $error("output enable low in late write");
    a_cbr_order: assert property (cbr_start |-> ##[1:2] $fell(pins_out.row_strobe_n))
        else $error("refresh row strobe missing");
    a_lane_gate: assert property (lane_p)
        else $error("column strobe lane wrong");
    a_drive_on_write: assert property (dq_oe_out != 2'b00 |-> !pins_out.write_en_n)
        else $error("data driven without write");
    a_precharge_gap: assert property ($rose(pins_out.row_strobe_n) |=> pins_out.row_strobe_n
        && lo_n && up_n) else $error("no precharge between cycles");
endmodule // edo_ctrl_monitor
bind edo_dram_cycle_control edo_ctrl_monitor u_mon (.core_clk_in(core_clk_in),
    .reset_in(reset_in), .req_valid_in(req_valid_in), .req_in(req_in),
    .req_ready_out(req_ready_out), .rdata_valid_out(rdata_valid_out),
    .init_done_out(init_done_out), .pins_out(pins_out), .dq_oe_out(dq_oe_out));

/* File: tb/edo_dram_model.sv */
/* Behavioural EDO DRAM with two byte column strobes.
 Assumes strobes and address come from the controller pins. */
`timescale 1ns/1ps
module edo_dram_model (
    input wire edo_ctrl_pkg::dram_pins_type pins_in,
    input wire logic [15:0] dq_in,
    input wire logic [1:0] dq_oe_in,
    output logic [15:0] dq_out,
    output int refresh_count_out
);
    edo_ctrl_pkg::dram_pins_type p_d;
    logic [15:0] mem [logic [17:0]];
    logic [8:0] row_q = 9'h000;
    logic [8:0] col_q = 9'h000;
    logic cbr_q = 1'b0;
    logic [15:0] rd;
    logic [1:0] drv;
    wire [17:0] k = {row_q, col_q};
    // Pre-edge copy of the pins
    assign #1 p_d = pins_in;
    initial refresh_count_out = 0;
    always @(negedge pins_in.row_strobe_n)
    begin
        cbr_q = !p_d.lower_byte_col_strobe_n || !p_d.upper_byte_col_strobe_n;
        if (cbr_q)
            refresh_count_out++;
        else
            row_q = p_d.addr;
    end
    always @(negedge pins_in.lower_byte_col_strobe_n or negedge pins_in.upper_byte_col_strobe_n)
        col_q = p_d.addr;
    always @*
    begin
        // Delayed pins so the column latch settles before a write
        if (!p_d.row_strobe_n && !cbr_q && !p_d.write_en_n)
        begin
            if (!p_d.lower_byte_col_strobe_n && dq_oe_in[0]) mem[k][7:0] = dq_in[7:0];
            if (!p_d.upper_byte_col_strobe_n && dq_oe_in[1]) mem[k][15:8] = dq_in[15:8];
        end
    end
    always @*
    begin
        rd = mem.exists(k) ? mem[k] : 16'h0000;
        drv[0] = !pins_in.lower_byte_col_strobe_n;
        drv[1] = !pins_in.upper_byte_col_strobe_n;
        drv = drv & {2{!pins_in.row_strobe_n && !pins_in.out_en_n
            && pins_in.write_en_n && !cbr_q}};
        dq_out[7:0] = drv[0] ? rd[7:0] : ~rd[7:0];
        dq_out[15:8] = drv[1] ? rd[15:8] : ~rd[15:8];
    end
endmodule // edo_dram_model

/* File: tb/tb.sv */
/* Self-checking bench for the EDO DRAM controller.
 Assumes the behavioural DRAM model on the pins. */
`timescale 1ns/1ps
module tb;
    logic core_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic req_valid_in = 1'b0;
    edo_ctrl_pkg::mem_req_type req_in = '0;
    logic req_ready_out, rdata_valid_out, init_done_out;
    logic [15:0] rdata_out, dq_out, dq_in, d;
    logic [1:0] dq_oe_out;
    logic [17:0] a;
    logic [31:0] e;
    edo_ctrl_pkg::dram_pins_type pins_out;
    int refresh_count;
    int miscompares = 0;
    int tests_run = 0;
    int cycles = 0;
    logic [15:0] exp_mem [logic [17:0]];
    logic [31:0] exp_q [$];
    edo_dram_cycle_control #(.WAKE_CYCLES(40)) DUT (.core_clk_in(core_clk_in),
        .reset_in(reset_in), .req_valid_in(req_valid_in), .req_in(req_in),
        .req_ready_out(req_ready_out), .rdata_valid_out(rdata_valid_out),
        .rdata_out(rdata_out), .init_done_out(init_done_out), .pins_out(pins_out),
        .dq_in(dq_in), .dq_out(dq_out), .dq_oe_out(dq_oe_out));
    edo_dram_model u_dram (.pins_in(pins_out), .dq_in(dq_out), .dq_oe_in(dq_oe_out),
        .dq_out(dq_in), .refresh_count_out(refresh_count));
    initial forever #12.5 core_clk_in = ~core_clk_in;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d errors %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic xfer(input logic w, input logic l, input logic [1:0] be,
        input logic [17:0] ad, input logic [15:0] wd);
        logic [15:0] m;
        m = {{8{be[1]}}, {8{be[0]}}};
        if (w)
            exp_mem[ad] = (exp_mem.exists(ad) ? exp_mem[ad] : 16'h0000) & ~m | wd & m;
        else
            exp_q.push_back({m, exp_mem[ad] & m});
        req_in <= '{write: w, late: l, byte_en: be, row: ad[17:9], col: ad[8:0], wdata: wd};
        req_valid_in <= 1'b1;
        do @(posedge core_clk_in); while (req_ready_out !== 1'b1);
        req_valid_in <= 1'b0;
        @(posedge core_clk_in);
    endtask
    // Timeout and read-data checker
    always @(posedge core_clk_in)
    begin
        cycles <= cycles + 1;
        if (rdata_valid_out === 1'b1)
        begin
            chk({15'h0000, exp_q.size() == 0}, 16'h0000);
            e = exp_q.pop_front();
            chk(rdata_out & e[31:16], e[15:0]);
        end
        if (cycles == 6000)
        begin
            miscompares++;
            summarize();
        end
    end
    initial
    begin
        void'($urandom(51));
        repeat (20) @(posedge core_clk_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 300 && init_done_out !== 1'b1; i++) @(posedge core_clk_in);
        chk({15'h0000, init_done_out}, 16'h0001);
        chk(16'(refresh_count), 16'h0008);
        for (int i = 0; i < 8; i++)
        begin
            a = 18'($urandom);
            d = 16'($urandom);
            xfer(1'b1, i[0], 2'b11, a, d);
            xfer(1'b0, 1'b0, 2'b11, a, 16'h0000);
        end
        xfer(1'b1, 1'b0, 2'b11, a, 16'($urandom));
        xfer(1'b1, 1'b1, 2'b01, a, 16'($urandom));
        xfer(1'b1, 1'b0, 2'b10, a, 16'($urandom));
        for (int i = 1; i < 4; i++) xfer(1'b0, 1'b0, 2'(i), a, 16'h0000);
        repeat (1400) @(posedge core_clk_in);
        chk({15'h0000, refresh_count >= 10}, 16'h0001);
        xfer(1'b0, 1'b0, 2'b11, a, 16'h0000);
        repeat (12) @(posedge core_clk_in);
        chk(16'(exp_q.size()), 16'h0000);
        summarize();
    end
endmodule // tb
